// >>> rtl/iocd_latch.sv
/*
  Bank of fault latches: an ok flag drops on a fault and rises again on a
  clear only once the fault has gone. Assumes synchronous inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module iocd_latch #(
  parameter int unsigned   N      = 6,
  parameter logic [N-1:0] RST_OK = '1
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         en_i,
  input  wire logic [N-1:0] fault_i,
  input  wire logic         clr_i,
  output logic      [N-1:0] ok_o
);
  // ---------------------------------------------------------------
  // one latch per indicator; a live fault beats a clear
  // ---------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_lat
    always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        ok_o[i] <= RST_OK[i];
      end else if (en_i) begin
        if (fault_i[i]) begin
          ok_o[i] <= 1'b0;
        end else if (clr_i) begin
          ok_o[i] <= 1'b1;
        end
      end
    end
  end
endmodule : iocd_latch
`default_nettype wire

// >>> rtl/iocd_parity.sv
/*
  Odd-parity check and generation for one bus word.
  Assumes the word and its parity bit arrive together.
*/
`timescale 1ns/1ps
`default_nettype none
module iocd_parity #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] data_i,
  input  wire logic         par_i,
  output logic              gen_o,
  output logic              err_o
);
  // ---------------------------------------------------------------
  // odd parity: word plus parity bit holds an odd number of ones
  // ---------------------------------------------------------------
  assign gen_o = ~(^data_i);
  assign err_o = ~(^{data_i, par_i});
endmodule : iocd_parity
`default_nettype wire

// >>> rtl/iocd_top.sv
/*
  Fault-diagnostic logic of a chained rack receiver: chain pass-through,
  parity check and generation, fault latches, diagnostic bytes at two
  selector-chosen addresses, and one interrupt.
  Assumes all inputs are synchronous to clk_i and that the chain master
  issues one-cycle strobes, never a read and a write together.
*/
// Operation
// - all options off acts as basic receiver
// - separate input and output address selectors
// - selectors decode like ordinary module addressing
// - diagnostic addresses ignored until access enabled
// - factory selector setting answers at 993
// - upstream signals pass to downstream port
// - detect parity, supply and cable faults
// - check received parity, generate driven parity
// - readable status gives fault type, place
// - last six indicators latch their faults
// - pushbutton clears latches whose fault ended
// - CPU latch reset only through diagnostic addresses
// - power cycle resets every latch
// - supply-good starts latched off after power
// - link timeout latches after one second silence
// - live parity clears on retry; output latch holds
// - blocking option withholds chain fault, sets bit2
// - address parity error on any received address
`timescale 1ns/1ps
`default_nettype none
module iocd_top
  import iocd_pkg::*;
#(
  parameter int unsigned WD_CYCLES = IOCD_WD_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  ce_i,
  // upstream chain access (register port)
  input  wire logic [IOCD_AW-1:0]    addr_i,
  input  wire logic                  addr_par_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wdata_par_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [7:0]            rd_data_o,
  output logic                       rd_par_o,
  output logic                       rd_hit_o,
  // downstream chain copy
  output logic      [IOCD_AW-1:0]    dn_addr_o,
  output logic                       dn_addr_par_o,
  output logic      [7:0]            dn_wdata_o,
  output logic                       dn_wdata_par_o,
  output logic                       dn_wr_o,
  output logic                       dn_rd_o,
  // selectors, options and sensed conditions
  input  wire logic [IOCD_SEL_W-1:0] in_sel_i,
  input  wire logic [IOCD_SEL_W-1:0] out_sel_i,
  input  wire logic [7:0]            opt_i,
  input  wire logic                  reset_btn_i,
  input  wire logic                  supply_ok_i,
  input  wire logic                  dn_chain_ok_i,
  input  wire logic                  xmit_ok_i,
  input  wire logic                  loc_par_err_i,
  input  wire logic                  chn_par_err_i,
  // fault returns and indicators
  output logic                       chain_fault_o,
  output logic                       out_par_err_o,
  output logic                       wd_reset_o,
  output logic      [11:0]           led_o,
  output logic                       irq_o
);
  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // group field of a point address compared with a selector setting,
  // the same pattern as any I/O module on the chain
  function automatic logic grp_match(input logic [IOCD_AW-1:0] a,
                                     input logic [IOCD_SEL_W-1:0] s);
    grp_match = (a[IOCD_AW-1:IOCD_GRP_LSB] == s);
  endfunction

  logic       addr_err, data_err, rd_par_gen;
  logic       diag_en, in_hit, out_hit;
  logic [1:0] bsel;

  iocd_parity #(.W(IOCD_AW)) u_apar (
    .data_i (addr_i),
    .par_i  (addr_par_i),
    .gen_o  (),
    .err_o  (addr_err)
  );

  iocd_parity #(.W(8)) u_dpar (
    .data_i (wdata_i),
    .par_i  (wdata_par_i),
    .gen_o  (),
    .err_o  (data_err)
  );

  // accesses with a bad address word are not taken as ours
  assign diag_en = opt_i[IOCD_O_DIAG_EN];
  assign in_hit  = rd_i & diag_en & ~addr_err & grp_match(addr_i, in_sel_i);
  assign out_hit = wr_i & diag_en & ~addr_err & ~data_err
                   & grp_match(addr_i, out_sel_i);
  assign bsel    = addr_i[IOCD_BYTE_LSB+1:IOCD_BYTE_LSB];

  // ---------------------------------------------------------------
  // chain pass-through
  // ---------------------------------------------------------------
  // one flop stage keeps outputs registered; unpowered bypass is a
  // connector matter outside this logic
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dn_addr_o      <= '0;
      dn_addr_par_o  <= 1'b0;
      dn_wdata_o     <= '0;
      dn_wdata_par_o <= 1'b0;
      dn_wr_o        <= 1'b0;
      dn_rd_o        <= 1'b0;
    end else if (ce_i) begin
      dn_addr_o      <= addr_i;
      dn_addr_par_o  <= addr_par_i;
      dn_wdata_o     <= wdata_i;
      dn_wdata_par_o <= wdata_par_i;
      dn_wr_o        <= wr_i;
      dn_rd_o        <= rd_i;
    end
  end

  // ---------------------------------------------------------------
  // live parity indicators
  // ---------------------------------------------------------------
  logic addr_ok_q, data_ok_q;

  // every strobe updates the address flag and every write the data flag, so a clean retry clears the error
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_ok_q <= 1'b1;
      data_ok_q <= 1'b1;
    end else if (ce_i) begin
      if (rd_i | wr_i) begin
        addr_ok_q <= ~addr_err;
      end
      if (wr_i) begin
        data_ok_q <= ~data_err;
      end
    end
  end

  // ---------------------------------------------------------------
  // host link watchdog
  // ---------------------------------------------------------------
  localparam int unsigned WD_W = $clog2(WD_CYCLES + 1);
  localparam logic [WD_W-1:0] WD_LIM = WD_W'(WD_CYCLES);
  logic [WD_W-1:0] wd_cnt_q;
  logic            wd_fault;

  // any strobe on the chain counts as traffic with the CPU
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wd_cnt_q <= '0;
    end else if (ce_i) begin
      if (rd_i | wr_i) begin
        wd_cnt_q <= '0;
      end else if (wd_cnt_q != WD_LIM) begin
        wd_cnt_q <= wd_cnt_q + 1'b1;
      end
    end
  end

  assign wd_fault = (wd_cnt_q == WD_LIM);

  // ---------------------------------------------------------------
  // control byte and CPU latch reset
  // ---------------------------------------------------------------
  logic cmd_q, blank_q, cpu_clr, btn_clr;

  assign cpu_clr = out_hit & (bsel == IOCD_B_STAT)
                   & wdata_i[IOCD_C_LATCH_RST] & ~cmd_q;
  assign btn_clr = reset_btn_i;

  // the command level is remembered so a held bit clears only once
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cmd_q   <= 1'b0;
      blank_q <= IOCD_BLANK_RST[0];
    end else if (ce_i && out_hit && bsel == IOCD_B_STAT) begin
      cmd_q   <= wdata_i[IOCD_C_LATCH_RST];
      blank_q <= wdata_i[IOCD_C_BLANK];
    end
  end

  // ---------------------------------------------------------------
  // fault latches
  // ---------------------------------------------------------------
  logic [IOCD_NLAT-1:0] lat_fault, lat_ok;

  always_comb begin
    lat_fault              = '0;
    lat_fault[IOCD_L_WD]   = wd_fault;
    lat_fault[IOCD_L_OPAR] = (rd_i | wr_i) & addr_err
                             | wr_i & data_err;
    lat_fault[IOCD_L_IPAR] = opt_i[IOCD_O_LOC_PAR] & loc_par_err_i
                             | opt_i[IOCD_O_CHN_PAR] & chn_par_err_i;
    lat_fault[IOCD_L_PS]   = ~supply_ok_i;
    lat_fault[IOCD_L_CHN]  = ~dn_chain_ok_i;
    lat_fault[IOCD_L_XMIT] = ~xmit_ok_i;
  end

  iocd_latch #(
    .N      (IOCD_NLAT),
    .RST_OK (IOCD_LAT_RST)
  ) u_lat (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .en_i    (ce_i),
    .fault_i (lat_fault),
    .clr_i   (cpu_clr | btn_clr),
    .ok_o    (lat_ok)
  );

  // ---------------------------------------------------------------
  // fault returns to the CPU
  // ---------------------------------------------------------------
  logic blocked;
  assign blocked = opt_i[IOCD_O_BLOCK_DN] & ~lat_ok[IOCD_L_CHN];

  // with every option off the faults go upstream as in the basic part
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chain_fault_o <= 1'b0;
      out_par_err_o <= 1'b0;
      wd_reset_o    <= 1'b0;
    end else if (ce_i) begin
      chain_fault_o <= ~dn_chain_ok_i & ~opt_i[IOCD_O_BLOCK_DN];
      out_par_err_o <= lat_fault[IOCD_L_OPAR] & ~opt_i[IOCD_O_NO_OPAR];
      wd_reset_o    <= wd_fault & ~opt_i[IOCD_O_NO_WDRST];
    end
  end

  // ---------------------------------------------------------------
  // interrupt: sticky events and mask
  // ---------------------------------------------------------------
  logic [IOCD_NLAT-1:0] ev_q, mask_q, ev_w1c;

  assign ev_w1c = (out_hit && bsel == IOCD_B_EVENT) ? wdata_i[IOCD_NLAT-1:0] : '0;

  // a fault in the same cycle as its clear stays set
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ev_q <= '0;
    end else if (ce_i) begin
      ev_q <= (ev_q & ~ev_w1c) | lat_fault;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mask_q <= '0;
    end else if (ce_i && out_hit && bsel == IOCD_B_MASK) begin
      mask_q <= wdata_i[IOCD_NLAT-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(ev_q & mask_q);
    end
  end

  // ---------------------------------------------------------------
  // diagnostic read data
  // ---------------------------------------------------------------
  logic [7:0] stat_byte, rd_mux;

  // type and place: live/latched flags name the fault and whether it
  // lies upstream, in this rack or downstream
  always_comb begin
    stat_byte                  = '0;
    stat_byte[IOCD_S_ADDR_OK]  = addr_ok_q;
    stat_byte[IOCD_S_DATA_OK]  = data_ok_q;
    stat_byte[IOCD_S_BLOCKED]  = blocked;
    stat_byte[IOCD_S_CHAIN_OK] = dn_chain_ok_i;
    stat_byte[IOCD_S_SUPPLY]   = supply_ok_i;
    stat_byte[IOCD_S_BLANK]    = blank_q;
    unique case (bsel)
      IOCD_B_STAT:  rd_mux = stat_byte;
      IOCD_B_LATCH: rd_mux = {2'b00, lat_ok};
      IOCD_B_EVENT: rd_mux = {2'b00, ev_q};
      IOCD_B_MASK:  rd_mux = {2'b00, mask_q};
    endcase
  end

  iocd_parity #(.W(8)) u_rpar (
    .data_i (rd_mux),
    .par_i  (1'b0),
    .gen_o  (rd_par_gen),
    .err_o  ()
  );

  // answer stands one cycle; a miss returns zero with good parity
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_data_o <= '0;
      rd_par_o  <= 1'b1;
      rd_hit_o  <= 1'b0;
    end else if (ce_i) begin
      rd_hit_o  <= in_hit;
      rd_data_o <= in_hit ? rd_mux : 8'h00;
      rd_par_o  <= in_hit ? rd_par_gen : 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      led_o <= '0;
    end else if (ce_i) begin
      led_o <= {lat_ok, 1'b0, blank_q, data_ok_q, addr_ok_q,
                ~chn_par_err_i, dn_chain_ok_i};
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  localparam logic [IOCD_AW-1:0] PT993 = IOCD_AW'(IOCD_FACTORY_POINT - 1);

  property p_diag_gate;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && !opt_i[IOCD_O_DIAG_EN] |=> !rd_hit_o && rd_data_o == 8'h00;
  endproperty
  a_diag_gate: assert property (p_diag_gate) else $error("read answered while disabled");

  property p_pass;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && rstn_i |=> dn_addr_o == $past(addr_i) && dn_wr_o == $past(wr_i);
  endproperty
  a_pass: assert property (p_pass) else $error("downstream copy wrong");

  property p_rpar;
    @(posedge clk_i) disable iff (!rstn_i)
      rd_hit_o |-> ^{rd_data_o, rd_par_o};
  endproperty
  a_rpar: assert property (p_rpar) else $error("read parity not odd");

  property p_once;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && cpu_clr |=> !cpu_clr;
  endproperty
  a_once: assert property (p_once) else $error("latch reset repeated");

  property p_wd;
    @(posedge clk_i) disable iff (!rstn_i)
      // the indicator copy lags the latch by one more edge
      ce_i && !(rd_i || wr_i) && wd_cnt_q == WD_LIM |=> !lat_ok[IOCD_L_WD] ##1 !led_o[6];
  endproperty
  a_wd: assert property (p_wd) else $error("timeout not latched");

  property p_hold;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && !supply_ok_i ##1 ce_i && reset_btn_i |=> !lat_ok[IOCD_L_PS];
  endproperty
  a_hold: assert property (p_hold) else $error("live fault cleared");

  property p_apar;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && (rd_i || wr_i) |=> addr_ok_q == !$past(addr_err)
                                 && (!$past(addr_err) || !lat_ok[IOCD_L_OPAR]);
  endproperty
  a_apar: assert property (p_apar) else $error("address parity flags wrong");

  property p_block;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && opt_i[IOCD_O_BLOCK_DN] && !dn_chain_ok_i
      |=> !chain_fault_o && !lat_ok[IOCD_L_CHN];
  endproperty
  a_block: assert property (p_block) else $error("chain fault not withheld");

  property p_basic;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && opt_i == 8'h00 |=> !rd_hit_o && chain_fault_o == !$past(dn_chain_ok_i);
  endproperty
  a_basic: assert property (p_basic) else $error("basic behaviour broken");

  property p_fact;
    @(posedge clk_i) disable iff (!rstn_i)
      ce_i && rd_i && diag_en && !addr_err && in_sel_i == IOCD_FACTORY_SEL
      && addr_i == PT993 |=> rd_hit_o;
  endproperty
  a_fact: assert property (p_fact) else $error("no answer at factory point");

  c_hit: cover property (@(posedge clk_i) disable iff (!rstn_i) rd_hit_o);
  c_clr: cover property (@(posedge clk_i) disable iff (!rstn_i) cpu_clr);
  c_irq: cover property (@(posedge clk_i) disable iff (!rstn_i) irq_o);
endmodule : iocd_top
`default_nettype wire

// >>> shared/iocd_pkg.sv
/*
  Constants for the chain fault-diagnostic block: bus address fields,
  diagnostic byte map, option bits, indicator layout, reset values, timing.
  Assumes a 20 MHz system clock.
*/
`default_nettype none
package iocd_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned IOCD_CLK_HZ   = 20_000_000;
  localparam int unsigned IOCD_WD_MS    = 1000;   // link silence limit, ms
  // longest time: rounds down
  localparam int unsigned IOCD_WD_CYCLES = (IOCD_CLK_HZ / 1000) * IOCD_WD_MS;

  // ---------------------------------------------------------------
  // chain address: point number minus one, 32-point groups
  // ---------------------------------------------------------------
  localparam int unsigned IOCD_AW      = 10;
  localparam int unsigned IOCD_GRP_LSB = 5;
  localparam int unsigned IOCD_SEL_W   = 5;
  localparam int unsigned IOCD_BYTE_LSB = 3;
  localparam logic [IOCD_SEL_W-1:0] IOCD_FACTORY_SEL = 5'h1F;
  localparam int unsigned IOCD_FACTORY_POINT = 993;

  // ---------------------------------------------------------------
  // diagnostic byte offsets within the selected group
  // ---------------------------------------------------------------
  localparam logic [1:0] IOCD_B_STAT  = 2'h0;  // in: live status / out: control
  localparam logic [1:0] IOCD_B_LATCH = 2'h1;  // in: latched ok flags
  localparam logic [1:0] IOCD_B_EVENT = 2'h2;  // sticky events, write one clears
  localparam logic [1:0] IOCD_B_MASK  = 2'h3;  // event mask

  // status byte bits
  localparam int unsigned IOCD_S_ADDR_OK  = 0;
  localparam int unsigned IOCD_S_DATA_OK  = 1;
  localparam int unsigned IOCD_S_BLOCKED  = 2;
  localparam int unsigned IOCD_S_CHAIN_OK = 3;
  localparam int unsigned IOCD_S_SUPPLY   = 4;
  localparam int unsigned IOCD_S_BLANK    = 5;
  // control byte bits
  localparam int unsigned IOCD_C_LATCH_RST = 0;
  localparam int unsigned IOCD_C_BLANK     = 1;

  // ---------------------------------------------------------------
  // option selector bits (zero = basic receiver behaviour)
  // ---------------------------------------------------------------
  localparam int unsigned IOCD_O_BLOCK_DN = 0;
  localparam int unsigned IOCD_O_DIAG_EN  = 2;
  localparam int unsigned IOCD_O_NO_OPAR  = 3;
  localparam int unsigned IOCD_O_NO_WDRST = 4;
  localparam int unsigned IOCD_O_LOC_PAR  = 5;
  localparam int unsigned IOCD_O_CHN_PAR  = 6;

  // ---------------------------------------------------------------
  // latched indicators
  // ---------------------------------------------------------------
  localparam int unsigned IOCD_NLAT   = 6;
  localparam int unsigned IOCD_L_WD   = 0;
  localparam int unsigned IOCD_L_OPAR = 1;
  localparam int unsigned IOCD_L_IPAR = 2;
  localparam int unsigned IOCD_L_PS   = 3;
  localparam int unsigned IOCD_L_CHN  = 4;
  localparam int unsigned IOCD_L_XMIT = 5;
  // supply-good starts latched off after power-up
  localparam logic [IOCD_NLAT-1:0] IOCD_LAT_RST = 6'h37;
  localparam logic [7:0] IOCD_BLANK_RST = 8'h01;
endpackage : iocd_pkg
`default_nettype wire

// >>> test/iocd_cpu_model.sv
/*
  Chain master model: issues one-cycle read or write strobes with odd parity.
  Assumes the receiver answers a read in the cycle after the strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module iocd_cpu_model (
  input  wire logic       clk_i,
  output logic      [9:0] addr_o,
  output logic            addr_par_o,
  output logic      [7:0] wdata_o,
  output logic            wdata_par_o,
  output logic            wr_o,
  output logic            rd_o
);
  // ---------------------------------------------------------------
  // idle lines and strobe task
  // ---------------------------------------------------------------
  initial begin
    {addr_o, addr_par_o, wdata_o, wdata_par_o, wr_o, rd_o} = '0;
  end
  // latch reset goes out only as a write to the output group
  // bad corrupts address parity; released address and data lines invert so nothing stale lingers
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d, input logic bad);
    @(posedge clk_i);
    addr_o      <= a;
    addr_par_o  <= ~^a ^ bad;
    wdata_o     <= d;
    wdata_par_o <= ~^d;
    wr_o        <= w;
    rd_o        <= !w;
    @(posedge clk_i);
    {wr_o, rd_o} <= 2'b00;
    addr_o       <= ~a;
    wdata_o      <= ~d;
  endtask
endmodule // iocd_cpu_model
`default_nettype wire

// >>> test/tb_top.sv
/*
  Self-checking bench for the chain diagnostic block, random groups drawn
  from a fixed seed. Assumes a 20 MHz clock and a short watchdog count.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_i, rstn_i, wr, rd, apar, dpar, btn, sup, chn, hit, rpar;
  logic       dnap, dnwp, dnwr, dnrd, cf, ope, wdr, irq, xok, lpe;
  logic [9:0] addr, dnad;
  logic [7:0] wd, opt, rdat, dnwd;
  logic [4:0] isel, osel, g;
  logic [11:0] led;
  int         seed = 22726;
  int         miscompares = 0;
  int         n_tests = 0;
  iocd_cpu_model u_cpu (.clk_i(clk_i), .addr_o(addr), .addr_par_o(apar), .wdata_o(wd),
    .wdata_par_o(dpar), .wr_o(wr), .rd_o(rd));
  iocd_top #(.WD_CYCLES(50)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .ce_i(1'b1),
    .addr_i(addr), .addr_par_i(apar), .wdata_i(wd), .wdata_par_i(dpar), .wr_i(wr),
    .rd_i(rd), .rd_data_o(rdat), .rd_par_o(rpar), .rd_hit_o(hit), .dn_addr_o(dnad),
    .dn_addr_par_o(dnap), .dn_wdata_o(dnwd), .dn_wdata_par_o(dnwp), .dn_wr_o(dnwr),
    .dn_rd_o(dnrd), .in_sel_i(isel), .out_sel_i(osel), .opt_i(opt), .reset_btn_i(btn),
    .supply_ok_i(sup), .dn_chain_ok_i(chn), .xmit_ok_i(xok), .loc_par_err_i(lpe),
    .chn_par_err_i(1'b0), .chain_fault_o(cf), .out_par_err_o(ope), .wd_reset_o(wdr),
    .led_o(led), .irq_o(irq));
  // ---------------------------------------------------------------
  // clock, helpers
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  function automatic logic [9:0] ad(input logic [4:0] grp, input logic [1:0] b);
    return {grp, b, 3'b000};
  endfunction
  task automatic chk(input string n, input logic [11:0] s, input logic [11:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // a read answers in the next cycle only; the chain copy lags one cycle too
  task automatic rdc(input logic [9:0] a, input logic h, input logic [7:0] d);
    u_cpu.xfer(1'b0, a, 8'h00, 1'b0);
    #1;
    chk("hit", hit, h);
    chk("rdata", rdat, d);
    chk("rdpar", rpar, ~^d);
    chk("pass", {dnrd, dnad, dnap}, {1'b1, a, ~^a});
  endtask
  task automatic wrt(input logic [9:0] a, input logic [7:0] d);
    u_cpu.xfer(1'b1, a, d, 1'b0);
    #1;
    chk("pass_wr", {dnwr, dnwd, dnwp}, {1'b1, d, ~^d});
  endtask
  task automatic pwr;
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, far beyond the roughly 165 cycles the run needs
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {rstn_i, btn, opt} = '0;
    {sup, chn, xok, lpe} = 4'b1110;
    isel = 5'h1F;
    osel = 5'h1F;
    pwr;
    chk("led_rst", led, 12'hDDF);
    rdc(ad(5'h1F, 2'd0), 1'b0, 8'h00);
    opt <= 8'h04;
    rdc(ad(5'h1F, 2'd0), 1'b1, 8'h3B);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h37);
    // other groups stay silent; the last draw becomes the output group
    for (int i = 0; i < 6; i++) begin
      g = 5'($random(seed));
      if (g == 5'h1F) g = 5'h00;
      rdc(ad(g, 2'd0), 1'b0, 8'h00);
    end
    osel <= g;
    wrt(ad(5'h1F, 2'd0), 8'h01);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h37);
    wrt(ad(g, 2'd0), 8'h01);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h3F);
    @(posedge clk_i) sup <= 1'b0;
    @(posedge clk_i) sup <= 1'b1;
    wrt(ad(g, 2'd0), 8'h01);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h37);
    wrt(ad(g, 2'd0), 8'h00);
    wrt(ad(g, 2'd0), 8'h01);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h3F);
    // pushbutton must not clear a fault that is still present
    @(posedge clk_i) sup <= 1'b0;
    @(posedge clk_i) btn <= 1'b1;
    @(posedge clk_i) btn <= 1'b0;
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h37);
    @(posedge clk_i) sup <= 1'b1;
    @(posedge clk_i) btn <= 1'b1;
    @(posedge clk_i) btn <= 1'b0;
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h3F);
    u_cpu.xfer(1'b0, ad(5'h1F, 2'd1), 8'h00, 1'b1);
    #1;
    chk("bad_hit", {hit, ope}, 2'b01);
    @(posedge clk_i) #1;
    chk("address_parity_indicator", led[2], 1'b0);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h3D);
    repeat (2) @(posedge clk_i);
    #1;
    chk("address_parity_indicator_ok", led[2], 1'b1);
    @(posedge clk_i) chn <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    chk("chain_fault", cf, 1'b1);
    opt <= 8'h05;
    repeat (3) @(posedge clk_i);
    #1;
    chk("chain_block", cf, 1'b0);
    rdc(ad(5'h1F, 2'd0), 1'b1, 8'h17);
    opt <= 8'h04;
    chn <= 1'b1;
    wrt(ad(g, 2'd0), 8'h00);
    wrt(ad(g, 2'd0), 8'h01);
    repeat (60) @(posedge clk_i);
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h3E);
    chk("wd_reset", wdr, 1'b1);
    // sticky events: masked quiet, unmasked raise, write-one clears
    wrt(ad(g, 2'd3), 8'h00);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq_masked", irq, 1'b0);
    wrt(ad(g, 2'd3), 8'hFF);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq_set", irq, 1'b1);
    wrt(ad(g, 2'd2), 8'hFF);
    repeat (2) @(posedge clk_i);
    #1;
    chk("irq_clr", irq, 1'b0);
    // local parity fault latches with its option set; transmit fault latches with no option
    opt <= 8'h24;
    @(posedge clk_i) {xok, lpe} <= 2'b01;
    @(posedge clk_i) {xok, lpe} <= 2'b10;
    rdc(ad(5'h1F, 2'd1), 1'b1, 8'h1A);
    // output parity return withheld by its option
    opt <= 8'h0C;
    u_cpu.xfer(1'b0, ad(5'h1F, 2'd1), 8'h00, 1'b1);
    #1;
    chk("opar_off", {hit, ope}, 2'b00);
    pwr;
    chk("led_pwr", led, 12'hDDF);
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
